// ---- hw/dsa_pkg.sv ----
// constants and operation codes for the signal-processing add unit
// assumes the pipeline decodes instructions into dsa_op_t codes before issue
package dsa_pkg;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned LANE_W    = 16;
  localparam int unsigned LANES     = 2;
  localparam int unsigned OP_W      = 4;
  localparam int unsigned CARRY_BIT = 13;            // carry field of the control register
  localparam int unsigned OUF_BIT   = 20;            // overflow sticky field
  localparam logic [31:0] CTL_RESET = 32'h00000000;
  localparam logic [15:0] LANE_MAX  = 16'hFFFF;      // unsigned halfword clamp value
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // decoded operation codes; codes past the last entry are reserved
  typedef enum logic [OP_W-1:0] {
    DSA_OP_HALFWORD_HALVING_ADD,
    DSA_OP_HALFWORD_HALVING_ADD_ROUNDED,
    DSA_OP_WORD_HALVING_ADD,
    DSA_OP_WORD_HALVING_ADD_ROUNDED,
    DSA_OP_CARRY_SETTING_ADD,
    DSA_OP_UNSIGNED_HALFWORD_ADD,
    DSA_OP_UNSIGNED_HALFWORD_ADD_SATURATING,
    DSA_OP_ADD_WITH_CARRY,
    DSA_OP_LAST
  } dsa_op_t;
endpackage

// ---- hw/dsa_add_unit.sv ----
// single-cycle datapath for the signal-processing add group with the control register
// assumes operands arrive synchronous to ref_clk; the pipeline stalls nothing, one op per cycle
`timescale 1ns/1ps
module dsa_add_unit (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        op_valid,
  input  wire logic [3:0]  op_code,
  input  wire logic        dsp_enable,
  input  wire logic [31:0] source_a_operand,
  input  wire logic [31:0] source_b_operand,
  input  wire logic        ctl_wr_en,
  input  wire logic [31:0] ctl_wr_data,
  output logic             result_valid,
  output logic [31:0]      result_data,
  output logic [31:0]      signal_proc_control_reg,
  output logic             exc_reserved,
  output logic             exc_dsp_disabled
);
  logic        result_valid_reg;
  logic [31:0] result_data_reg;
  logic [31:0] ctl_reg;
  logic        exc_reserved_reg;
  logic        exc_disabled_reg;
  logic [31:0] ctl_base;
  logic [31:0] ctl_next;
  logic [31:0] result_next;

  // decode of the issued operation
  wire logic op_known  = op_code < dsa_pkg::OP_W'(dsa_pkg::DSA_OP_LAST);
  wire logic exec      = op_valid && dsp_enable && op_known;
  wire logic is_hh     = op_code == dsa_pkg::DSA_OP_HALFWORD_HALVING_ADD;
  wire logic is_hh_r   = op_code == dsa_pkg::DSA_OP_HALFWORD_HALVING_ADD_ROUNDED;
  wire logic is_wh     = op_code == dsa_pkg::DSA_OP_WORD_HALVING_ADD;
  wire logic is_wh_r   = op_code == dsa_pkg::DSA_OP_WORD_HALVING_ADD_ROUNDED;
  wire logic is_csa    = op_code == dsa_pkg::DSA_OP_CARRY_SETTING_ADD;
  wire logic is_uh     = op_code == dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD;
  wire logic is_uh_s   = op_code == dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD_SATURATING;
  wire logic is_awc    = op_code == dsa_pkg::DSA_OP_ADD_WITH_CARRY;
  wire logic carry_in  = ctl_reg[dsa_pkg::CARRY_BIT];

  // per-lane halfword arithmetic, both signed halving and unsigned forms
  logic [dsa_pkg::WORD_W-1:0] hh_res;
  logic [dsa_pkg::WORD_W-1:0] uh_res;
  logic [dsa_pkg::LANES-1:0]  uh_ovf;
  genvar g;
  generate
    for (g = 0; g < dsa_pkg::LANES; g++) begin : g_lane
      wire logic [15:0] la = source_a_operand[g*dsa_pkg::LANE_W +: dsa_pkg::LANE_W];
      wire logic [15:0] lb = source_b_operand[g*dsa_pkg::LANE_W +: dsa_pkg::LANE_W];
      // sign extension to 17 bits keeps the halved result exact
      wire logic [16:0] hsum = {la[15], la} + {lb[15], lb} + {16'h0000, is_hh_r};
      wire logic [16:0] usum = {1'b0, la} + {1'b0, lb};
      assign hh_res[g*dsa_pkg::LANE_W +: dsa_pkg::LANE_W] = hsum[16:1];
      assign uh_res[g*dsa_pkg::LANE_W +: dsa_pkg::LANE_W] =
        (is_uh_s && usum[16]) ? dsa_pkg::LANE_MAX : usum[15:0];
      assign uh_ovf[g] = usum[16];
    end
  endgenerate

  // word forms: halving, carry-setting and carry-consuming adds
  wire logic [32:0] wh_sum  = {source_a_operand[31], source_a_operand} +
                              {source_b_operand[31], source_b_operand} + {32'h00000000, is_wh_r};
  wire logic [32:0] csa_sum = {1'b0, source_a_operand} + {1'b0, source_b_operand};
  wire logic [32:0] awc_sum = {source_a_operand[31], source_a_operand} +
                              {source_b_operand[31], source_b_operand} + {32'h00000000, carry_in};
  wire logic awc_ovf = awc_sum[32] != awc_sum[31];
  wire logic ouf_set = exec && (((is_uh || is_uh_s) && (|uh_ovf)) || (is_awc && awc_ovf));

  // result select; unknown codes give zero and never reach the register file
  always_comb begin
    result_next = dsa_pkg::WORD_ZERO;
    if (is_hh || is_hh_r) begin
      result_next = hh_res;
    end else if (is_wh || is_wh_r) begin
      result_next = wh_sum[32:1];
    end else if (is_csa) begin
      result_next = csa_sum[31:0];
    end else if (is_uh || is_uh_s) begin
      result_next = uh_res;
    end else if (is_awc) begin
      result_next = awc_sum[31:0];
    end
  end

  // control register: pipeline write first, then the op's own updates; set wins over a clearing write
  assign ctl_base = ctl_wr_en ? ctl_wr_data : ctl_reg;
  always_comb begin
    ctl_next = ctl_base;                                        // halving ops fall through
    if (exec && is_csa) begin
      ctl_next[dsa_pkg::CARRY_BIT] = csa_sum[32];
    end
    if (ouf_set) begin
      ctl_next[dsa_pkg::OUF_BIT] = 1'b1;                        // sticky
    end
  end

  // result and control state commit on the same edge so a follower sees both
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      result_valid_reg <= 1'b0;
      result_data_reg  <= dsa_pkg::WORD_ZERO;
      ctl_reg          <= dsa_pkg::CTL_RESET;
      exc_reserved_reg <= 1'b0;
      exc_disabled_reg <= 1'b0;
    end else begin
      result_valid_reg <= exec;
      result_data_reg  <= exec ? result_next : result_data_reg;
      ctl_reg          <= ctl_next;
      exc_reserved_reg <= op_valid && !op_known;
      exc_disabled_reg <= op_valid && op_known && !dsp_enable;
    end
  end

  assign result_valid            = result_valid_reg;
  assign result_data             = result_data_reg;
  assign signal_proc_control_reg = ctl_reg;
  assign exc_reserved            = exc_reserved_reg;
  assign exc_dsp_disabled        = exc_disabled_reg;

  // reference values built independently: signed sums for halving forms, unsigned for lanes and carry
  wire logic [16:0] chk_hh_lo = 17'($signed(source_a_operand[15:0]) + $signed(source_b_operand[15:0]));
  wire logic [16:0] chk_hh_hi = 17'($signed(source_a_operand[31:16]) + $signed(source_b_operand[31:16]));
  wire logic [32:0] chk_word  = 33'($signed(source_a_operand) + $signed(source_b_operand));
  wire logic [16:0] chk_u_lo  = 17'(source_a_operand[15:0]) + 17'(source_b_operand[15:0]);
  wire logic [16:0] chk_u_hi  = 17'(source_a_operand[31:16]) + 17'(source_b_operand[31:16]);
  // rounded forms wrap inside the interim width, as the datapath sum does
  wire logic [16:0] chk_hh_lo_r = chk_hh_lo + 17'h00001;
  wire logic [16:0] chk_hh_hi_r = chk_hh_hi + 17'h00001;
  wire logic [32:0] chk_word_r  = chk_word + 33'h000000001;
  wire logic        chk_csa_cy  = (33'(source_a_operand) + 33'(source_b_operand)) > 33'h0FFFFFFFF;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence issue_s(logic sel);
    op_valid && dsp_enable && sel;
  endsequence
  sequence commit_s;
    result_valid;
  endsequence

  // halving forms: signed lane and word sums, rounded and not
  hh_lane_a: assert property (issue_s(is_hh) |=> commit_s ##0
    (result_data[15:0] == $past(chk_hh_lo[16:1]) && result_data[31:16] == $past(chk_hh_hi[16:1])))
    else $error("halfword halving result wrong");
  hh_order_a: assert property (issue_s(is_hh_r && source_a_operand[31:16] != source_a_operand[15:0])
    |=> result_data[31:16] == $past(chk_hh_hi_r[16:1]))
    else $error("upper lane placement wrong");
  hh_round_a: assert property (issue_s(is_hh_r) |=>
    result_data[15:0] == $past(chk_hh_lo_r[16:1]))
    else $error("rounded halfword wrong");
  word_half_a: assert property (issue_s(is_wh) |=> result_data == $past(chk_word[32:1]))
    else $error("word halving result wrong");
  word_round_a: assert property (issue_s(is_wh_r) |=>
    result_data == $past(chk_word_r[32:1]))
    else $error("rounded word wrong");
  // a pipeline write in the same cycle is the only thing allowed to move the register
  halve_ctl_a: assert property (issue_s(is_hh || is_hh_r || is_wh || is_wh_r) |=>
    signal_proc_control_reg == $past(ctl_wr_en ? ctl_wr_data : signal_proc_control_reg))
    else $error("halving op changed control register");

  // carry-setting add and the add that consumes its carry
  csa_low_a: assert property (issue_s(is_csa) |=>
    result_data == $past(source_a_operand + source_b_operand))
    else $error("carry add result wrong");
  carry_set_a: assert property (issue_s(is_csa) |=>
    signal_proc_control_reg[dsa_pkg::CARRY_BIT] == $past(chk_csa_cy))
    else $error("carry bit not copied");
  carry_ouf_a: assert property (issue_s(is_csa) |=>
    signal_proc_control_reg[dsa_pkg::OUF_BIT] ==
    $past(ctl_wr_en ? ctl_wr_data[dsa_pkg::OUF_BIT] : signal_proc_control_reg[dsa_pkg::OUF_BIT]))
    else $error("carry add touched overflow bit");
  awc_carry_a: assert property (issue_s(is_csa) ##1 issue_s(is_awc && !ctl_wr_en) |=>
    result_data == $past(source_a_operand) + $past(source_b_operand) + 32'($past(chk_csa_cy, 2)))
    else $error("carry not consumed");
  // both halves of the commit must land on one edge
  commit_pair_a: assert property (issue_s(is_csa) |=> commit_s ##0
    (signal_proc_control_reg[dsa_pkg::CARRY_BIT] == $past(chk_csa_cy) &&
     result_data == $past(source_a_operand + source_b_operand)))
    else $error("result and control update split");

  // unsigned halfword lanes and the sticky overflow bit
  uh_wrap_a: assert property (issue_s(is_uh) |=> result_data[15:0] == $past(chk_u_lo[15:0]))
    else $error("unsigned lane did not wrap");
  uh_sat_a: assert property (issue_s(is_uh_s && chk_u_lo[16]) |=>
    result_data[15:0] == dsa_pkg::LANE_MAX)
    else $error("unsigned lane not clamped");
  uh_hi_sat_a: assert property (issue_s(is_uh_s && chk_u_hi[16]) |=>
    result_data[31:16] == dsa_pkg::LANE_MAX)
    else $error("upper unsigned lane not clamped");
  ouf_sticky_a: assert property (issue_s((is_uh || is_uh_s) && chk_u_lo[16]) |=>
    signal_proc_control_reg[dsa_pkg::OUF_BIT] ##1
    ($stable(signal_proc_control_reg[dsa_pkg::OUF_BIT]) || $past(ctl_wr_en)))
    else $error("overflow sticky bit not set");
  ouf_keep_a: assert property (issue_s(is_uh && !chk_u_lo[16] && !chk_u_hi[16] && !ctl_wr_en) |=>
    $stable(signal_proc_control_reg))
    else $error("quiet unsigned add moved control register");

  // exceptions: only the reserved and disabled kinds, never from data
  no_exc_a: assert property (issue_s(op_known) |=> !exc_reserved && !exc_dsp_disabled)
    else $error("data-dependent exception raised");
  exc_prio_a: assert property (op_valid && op_code >= dsa_pkg::DSA_OP_LAST |=>
    exc_reserved && !exc_dsp_disabled && !result_valid)
    else $error("reserved op not refused");
  dis_exc_a: assert property (op_valid && !dsp_enable && !ctl_wr_en &&
    op_code < dsa_pkg::DSA_OP_LAST |=> exc_dsp_disabled && !result_valid && $stable(signal_proc_control_reg))
    else $error("disabled op not refused");
endmodule

// ---- test/dsa_pipe_model.sv ----
// pipeline model: issues decoded ops and control writes to the add unit
// assumes callers enter its tasks 2 ns after a rising ref_clk edge
`timescale 1ns/1ps
module dsa_pipe_model (
  input  wire logic        ref_clk,
  output logic             op_valid,
  output logic [3:0]       op_code,
  output logic             dsp_enable,
  output logic [31:0]      source_a_operand,
  output logic [31:0]      source_b_operand,
  output logic             ctl_wr_en,
  output logic [31:0]      ctl_wr_data
);
  // quiet pipeline at time zero
  initial begin
    op_valid = 1'b0;
    op_code = 4'h0;
    dsp_enable = 1'b1;
    source_a_operand = 32'h00000000;
    source_b_operand = 32'h00000000;
    ctl_wr_en = 1'b0;
    ctl_wr_data = 32'h00000000;
  end

  // op is held past its taking edge so back-to-back issue never drops op_valid
  task automatic issue(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b);
    op_valid = 1'b1;
    op_code = c;
    source_a_operand = a;
    source_b_operand = b;
    @(posedge ref_clk);
    #2;
  endtask

  // control write, held like an op until idle
  task automatic wr_ctl(input logic [31:0] d);
    ctl_wr_en = 1'b1;
    ctl_wr_data = d;
    @(posedge ref_clk);
    #2;
  endtask

  // released buses show inverted data so a stale value cannot pass for a live one
  task automatic idle();
    op_valid = 1'b0;
    ctl_wr_en = 1'b0;
    source_a_operand = ~source_a_operand;
    source_b_operand = ~source_b_operand;
    ctl_wr_data = ~ctl_wr_data;
  endtask

  // op and control write raised for the same edge; the write lands first
  task automatic issue_wr(input logic [3:0] c, input logic [31:0] a, input logic [31:0] b, input logic [31:0] d);
    ctl_wr_en = 1'b1;
    ctl_wr_data = d;
    issue(c, a, b);
  endtask

  // enable level is owned here so the line keeps a single driver
  task automatic set_enable(input logic en);
    dsp_enable = en;
  endtask
endmodule

// ---- test/dsa_add_unit_tb.sv ----
// self-checking bench for the add unit, driven through the pipeline model
// assumes one-cycle answers as registered outputs and synchronous active-low reset
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module dsa_add_unit_tb;
  logic        ref_clk, rstn, op_valid, dsp_enable, ctl_wr_en, result_valid, exc_reserved, exc_dsp_disabled;
  logic [3:0]  op_code;
  logic [31:0] src_a, src_b, ctl_wr_data, result_data, ctl;
  int          miscompares = 0;
  int          n_tests = 0;

  dsa_add_unit dut_u (.ref_clk(ref_clk), .rstn(rstn), .op_valid(op_valid), .op_code(op_code),
    .dsp_enable(dsp_enable), .source_a_operand(src_a), .source_b_operand(src_b), .ctl_wr_en(ctl_wr_en),
    .ctl_wr_data(ctl_wr_data), .result_valid(result_valid), .result_data(result_data),
    .signal_proc_control_reg(ctl), .exc_reserved(exc_reserved), .exc_dsp_disabled(exc_dsp_disabled));
  dsa_pipe_model pipe_u (.ref_clk(ref_clk), .op_valid(op_valid), .op_code(op_code), .dsp_enable(dsp_enable),
    .source_a_operand(src_a), .source_b_operand(src_b), .ctl_wr_en(ctl_wr_en), .ctl_wr_data(ctl_wr_data));

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // one op, then its one-cycle answer and the control word beside it
  task automatic run_op(input logic [3:0] c, input logic [31:0] a, b, r, k);
    pipe_u.issue(c, a, b);
    `CHK("result_valid", 1'b1, result_valid)
    `CHK("result_data", r, result_data)
    `CHK("control", k, ctl)
    `CHK("exceptions", 2'b00, {exc_reserved, exc_dsp_disabled})
  endtask

  // halving adds, signed lanes and words, with control preloaded to catch stray writes
  task automatic halving_ops();
    pipe_u.wr_ctl(32'h00102000);
    pipe_u.idle();
    run_op(dsa_pkg::DSA_OP_HALFWORD_HALVING_ADD, 32'h7FFF8000, 32'h00018001, 32'h40008000, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_HALFWORD_HALVING_ADD_ROUNDED, 32'h7FFF8000, 32'h00018001, 32'h40008001, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_WORD_HALVING_ADD, 32'h7FFFFFFF, 32'h00000002, 32'h40000000, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_WORD_HALVING_ADD_ROUNDED, 32'h7FFFFFFF, 32'h00000002, 32'h40000001, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_WORD_HALVING_ADD, 32'h80000000, 32'h80000000, 32'h80000000, 32'h00102000);
    pipe_u.idle();
  endtask

  // carry set, consumed back to back, then cleared; sticky bit stays set throughout
  task automatic carry_ops();
    pipe_u.wr_ctl(32'h00100000);
    pipe_u.idle();
    run_op(dsa_pkg::DSA_OP_CARRY_SETTING_ADD, 32'hFFFFFFFF, 32'h00000001, 32'h00000000, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_ADD_WITH_CARRY, 32'h00000000, 32'h00000000, 32'h00000001, 32'h00102000);
    run_op(dsa_pkg::DSA_OP_CARRY_SETTING_ADD, 32'h00000001, 32'h00000001, 32'h00000002, 32'h00100000);
    pipe_u.idle();
  endtask

  // unsigned lanes: no overflow, wrap, and clamp
  task automatic unsigned_ops();
    pipe_u.wr_ctl(32'h00000000);
    pipe_u.idle();
    run_op(dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD, 32'h00010001, 32'h00020003, 32'h00030004, 32'h00000000);
    run_op(dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD, 32'hFFFF0001, 32'h00020001, 32'h00010002, 32'h00100000);
    pipe_u.idle();
    pipe_u.wr_ctl(32'h00000000);
    pipe_u.idle();
    run_op(dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD_SATURATING, 32'hFFFF0001, 32'h00020001, 32'hFFFF0002, 32'h00100000);
    pipe_u.idle();
  endtask

  // refused ops pulse their exception and leave result and control alone
  task automatic refused_ops();
    pipe_u.issue(4'h8, 32'hFFFFFFFF, 32'h00000001);
    `CHK("reserved", 3'b100, {exc_reserved, exc_dsp_disabled, result_valid})
    pipe_u.set_enable(1'b0);
    pipe_u.issue(dsa_pkg::DSA_OP_CARRY_SETTING_ADD, 32'hFFFFFFFF, 32'h00000001);
    `CHK("disabled", 3'b010, {exc_reserved, exc_dsp_disabled, result_valid})
    `CHK("kept result", 32'hFFFF0002, result_data)
    `CHK("kept control", 32'h00100000, ctl)
    pipe_u.issue(4'hF, 32'h00000001, 32'h00000001);
    `CHK("reserved first", 3'b100, {exc_reserved, exc_dsp_disabled, result_valid})
    pipe_u.idle();
    pipe_u.set_enable(1'b1);
  endtask

  // write and op on one edge: write lands first, then the op's own bits win
  task automatic write_and_op();
    pipe_u.issue_wr(dsa_pkg::DSA_OP_UNSIGNED_HALFWORD_ADD, 32'h0000FFFF, 32'h00000001, 32'h00002000);
    `CHK("set over write", 32'h00102000, ctl)
    `CHK("wrap with write", 32'h00000000, result_data)
    pipe_u.issue_wr(dsa_pkg::DSA_OP_CARRY_SETTING_ADD, 32'h00000001, 32'h00000001, 32'h00102000);
    `CHK("carry over write", 32'h00100000, ctl)
    `CHK("valid with write", 1'b1, result_valid)
    pipe_u.idle();
  endtask

  // reset in mid-run clears results and control, then the next op is taken at once
  task automatic mid_reset();
    rstn = 1'b0;
    @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    `CHK("mid reset outputs", 35'h0, {result_valid, exc_reserved, exc_dsp_disabled, result_data})
    `CHK("mid reset control", dsa_pkg::CTL_RESET, ctl)
    pipe_u.issue(dsa_pkg::DSA_OP_CARRY_SETTING_ADD, 32'h80000000, 32'h80000000);
    `CHK("first op after reset", 32'h00002000, ctl)
    pipe_u.idle();
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence: 3-cycle reset, then each scenario
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #2;
    rstn = 1'b1;
    `CHK("reset outputs", 35'h0, {result_valid, exc_reserved, exc_dsp_disabled, result_data})
    `CHK("reset control", dsa_pkg::CTL_RESET, ctl)
    halving_ops();
    carry_ops();
    unsigned_ops();
    refused_ops();
    write_and_op();
    mid_reset();
    stop_test();
  end

  // hang guard; the run needs well under 100 cycles
  initial begin
    #100000;
    miscompares++;
    stop_test();
  end
endmodule
